// File: rtl/csg_pkg.sv
package csg_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PHASES = 3;
    // register byte addresses
    localparam logic [7:0] AMP_CONFIG_ADDR = 8'h00;
    localparam logic [7:0] SENSOR_CONFIG_ADDR = 8'h04;
    localparam logic [7:0] OCP_LEVEL_ADDR = 8'h08;
    localparam logic [7:0] BLANK_TIME_ADDR = 8'h0C;
    localparam logic [7:0] STATUS_ADDR = 8'h10;
    // amp_config_reg fields
    localparam int EN_LSB = 0;
    localparam int OFS_LSB = 3;
    localparam int OFS_W = 2;
    localparam int GAIN_LSB = 5;
    localparam int GAIN_W = 3;
    localparam int TRUNC_BIT = 8;
    // sensor_config_reg fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int RDSON_BIT = 2;
    localparam int SINGLE_BIT = 3;
    localparam int CALIB_BIT = 4;
    // ocp level fields
    localparam int THR_W = 4;
    localparam int PTHR_LSB = 0;
    localparam int NTHR_LSB = 4;
    // blank time
    localparam int BLANK_W = 8;
    // status fields
    localparam int ST_CONN_LSB = 0;
    localparam int ST_BLANK_LSB = 3;
    localparam int ST_POS_LSB = 6;
    localparam int ST_NEG_LSB = 9;
    localparam int ST_DRV_BIT = 12;
    // reset values
    localparam logic [2:0] EN_RST = 3'h0;
    localparam logic [1:0] OFS_RST = 2'h0;
    localparam logic [2:0] GAIN_RST = 3'h0;
    localparam logic [3:0] THR_RST = 4'h0;
    localparam logic [7:0] BLANK_RST = 8'h00;
    localparam logic [7:0] BLANK_ONE = 8'h01;

    // timing modes; low gate on encodes as zero
    typedef enum logic [1:0] {
        CSG_LOW_GATE_ON,
        CSG_HIGH_GATE_OFF,
        CSG_ALWAYS_ON,
        CSG_ALWAYS_OFF
    } csg_mode_e;
endpackage

// File: rtl/csg_phase.sv
`timescale 1ns/1ps
module csg_phase #(
    parameter int BLANK_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // configuration
    input wire logic enable,
    input wire csg_pkg::csg_mode_e mode,
    input wire logic single_shunt,
    input wire logic [BLANK_W-1:0] blank_len,
    // synchronised gate levels
    input wire logic gl_own,
    input wire logic gl_any,
    input wire logic gh_own,
    input wire logic gh_all,
    // results
    output logic connect,
    output logic blanking,
    output logic autozero
);
    logic connect_reg, connect_next;
    logic blank_reg, blank_next;
    logic az_reg, az_next;
    logic gh_prev_reg, gh_prev_next;
    logic [BLANK_W-1:0] cnt_reg, cnt_next;
    logic gate_on, high_gate_off_mode, on;

    // ----------------------------------------
    // gating and blanking
    // ----------------------------------------
    always_comb
    begin
        gate_on = single_shunt ? gl_any : gl_own;
        high_gate_off_mode = single_shunt ? !gh_all : !gh_own;
        case (mode)
            csg_pkg::CSG_LOW_GATE_ON: on = gate_on;
            csg_pkg::CSG_HIGH_GATE_OFF: on = high_gate_off_mode;
            csg_pkg::CSG_ALWAYS_ON: on = 1'b1;
            default: on = 1'b0;
        endcase
        connect_next = enable && on;
        gh_prev_next = gh_own;
        az_next = gh_own && !gh_prev_reg;
        cnt_next = cnt_reg;
        if (gh_own != gh_prev_reg)
        begin
            cnt_next = blank_len;
        end
        else if (cnt_reg != '0)
        begin
            cnt_next = cnt_reg - BLANK_W'(1);
        end
        blank_next = (cnt_next != '0);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            connect_reg <= 1'b0;
            blank_reg <= 1'b0;
            az_reg <= 1'b0;
            gh_prev_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else
        begin
            connect_reg <= connect_next;
            blank_reg <= blank_next;
            az_reg <= az_next;
            gh_prev_reg <= gh_prev_next;
            cnt_reg <= cnt_next;
        end
    end

    assign connect = connect_reg;
    assign blanking = blank_reg;
    assign autozero = az_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    disabled_stays_off_a: assert property (@(posedge sys_clk) disable iff (reset)
        !enable |=> !connect_reg) else $error("disabled amplifier connected");
    always_on_conn_a: assert property (@(posedge sys_clk) disable iff (reset)
        (enable && mode == csg_pkg::CSG_ALWAYS_ON) |=> connect_reg)
        else $error("always on output not connected");
    low_gate_conn_a: assert property (@(posedge sys_clk) disable iff (reset)
        (enable && mode == csg_pkg::CSG_LOW_GATE_ON && !single_shunt)
        |=> (connect_reg == $past(gl_own))) else $error("low gate gating wrong");
    autozero_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
        (gh_own && !gh_prev_reg) |=> autozero ##1 !autozero)
        else $error("auto zero pulse wrong");
    blank_start_a: assert property (@(posedge sys_clk) disable iff (reset)
        ($changed(gh_own) && blank_len != '0) |=> blank_reg ##1 blank_reg == $past(blank_len) > 1)
        else $error("blanking not started on gate edge");
endmodule

// File: rtl/csg_top.sv
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
// Operation
// - each of three amplifiers has own enable
// - four timing modes select output connection
// - disabled amplifier output never connected
// - low-gate-on connects while own low gate
// - single shunt uses OR of low gates
// - multiple amplifiers use their own phase gate
// - high-gate-off connects whenever high gate off
// - always-on keeps enabled outputs connected
// - on-resistance sensing forces mode zero
// - route drain or source to positive input
// - offset level selectable among four values
// - shared positive and negative threshold levels
// - positive comparator can truncate PWM drive
// - blank amplifier on high gate transitions
// - auto-zero on high gate rising edges
// - blanked output shows only the offset
module csg_top #(
    parameter int PHASES = csg_pkg::PHASES,
    parameter int BLANK_W = csg_pkg::BLANK_W
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [csg_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [csg_pkg::DATA_W-1:0] wb_dat_i,
    output logic [csg_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // gate drive and comparator pins
    input wire logic [PHASES-1:0] low_side_gate_n,
    input wire logic [PHASES-1:0] high_side_gate_n,
    input wire logic [PHASES-1:0] pos_comp_in,
    input wire logic [PHASES-1:0] neg_comp_in,
    input wire logic driver_enable_pin,
    // amplifier control
    output logic [PHASES-1:0] sense_output_n,
    output logic [PHASES-1:0] input_blank,
    output logic [PHASES-1:0] autozero_pulse,
    output logic [PHASES-1:0] amp_enable,
    output logic drain_to_positive,
    output logic [csg_pkg::OFS_W-1:0] offset_select,
    output logic [csg_pkg::GAIN_W-1:0] gain_select,
    output logic [csg_pkg::THR_W-1:0] pos_threshold,
    output logic [csg_pkg::THR_W-1:0] neg_threshold,
    output logic calibration_mode,
    output logic [PHASES-1:0] pwm_truncate
);
    localparam int SW = 4 * PHASES + 1;
    localparam int MULTI_AMPS = 2;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [SW-1:0] meta_reg, meta_next, sync_reg, sync_next;
    logic [PHASES-1:0] gl_s, gh_s, pos_s, neg_s;
    logic drv_s;

    always_comb
    begin
        meta_next = {driver_enable_pin, neg_comp_in, pos_comp_in,
            high_side_gate_n, low_side_gate_n};
        sync_next = meta_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign {drv_s, neg_s, pos_s, gh_s, gl_s} = sync_reg;

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [PHASES-1:0] en_reg, en_next;
    logic [csg_pkg::OFS_W-1:0] ofs_reg, ofs_next;
    logic [csg_pkg::GAIN_W-1:0] gain_reg, gain_next;
    logic trunc_reg, trunc_next;
    csg_pkg::csg_mode_e mode_reg, mode_next;
    logic rdson_reg, rdson_next;
    logic single_reg, single_next;
    logic calib_reg, calib_next;
    logic [csg_pkg::THR_W-1:0] pthr_reg, pthr_next, nthr_reg, nthr_next;
    logic [BLANK_W-1:0] blank_reg, blank_next;
    logic ack_reg, ack_next;
    logic [csg_pkg::DATA_W-1:0] rdat_reg, rdat_next;
    logic [PHASES-1:0] trn_reg, trn_next;
    logic [PHASES-1:0] conn, blnk, az;
    logic req, wr;
    logic shared_gate;

    always_comb
    begin
        req = wb_cyc_i && wb_stb_i && !ack_reg;
        wr = req && wb_we_i && wb_sel_i[0];
        en_next = en_reg;
        ofs_next = ofs_reg;
        gain_next = gain_reg;
        trunc_next = trunc_reg;
        mode_next = mode_reg;
        rdson_next = rdson_reg;
        single_next = single_reg;
        calib_next = calib_reg;
        pthr_next = pthr_reg;
        nthr_next = nthr_reg;
        blank_next = blank_reg;
        if (wr)
        begin
            case (wb_adr_i)
                csg_pkg::AMP_CONFIG_ADDR:
                begin
                    en_next = wb_dat_i[csg_pkg::EN_LSB +: PHASES];
                    ofs_next = wb_dat_i[csg_pkg::OFS_LSB +: csg_pkg::OFS_W];
                    gain_next = wb_dat_i[csg_pkg::GAIN_LSB +: csg_pkg::GAIN_W];
                end
                csg_pkg::SENSOR_CONFIG_ADDR:
                begin
                    mode_next = csg_pkg::csg_mode_e'(
                        wb_dat_i[csg_pkg::MODE_LSB +: csg_pkg::MODE_W]);
                    rdson_next = wb_dat_i[csg_pkg::RDSON_BIT];
                    single_next = wb_dat_i[csg_pkg::SINGLE_BIT];
                    calib_next = wb_dat_i[csg_pkg::CALIB_BIT];
                end
                csg_pkg::OCP_LEVEL_ADDR:
                begin
                    pthr_next = wb_dat_i[csg_pkg::PTHR_LSB +: csg_pkg::THR_W];
                    nthr_next = wb_dat_i[csg_pkg::NTHR_LSB +: csg_pkg::THR_W];
                end
                csg_pkg::BLANK_TIME_ADDR:
                begin
                    blank_next = wb_dat_i[BLANK_W-1:0];
                end
                default:
                begin
                    blank_next = blank_reg;
                end
            endcase
        end
        // truncate enable sits alone in byte 1 of the amp config word
        if (req && wb_we_i && wb_sel_i[1] && wb_adr_i == csg_pkg::AMP_CONFIG_ADDR)
        begin
            trunc_next = wb_dat_i[csg_pkg::TRUNC_BIT];
        end
        if (rdson_next)
        begin
            mode_next = csg_pkg::CSG_LOW_GATE_ON;
        end
        ack_next = req;
        rdat_next = '0;
        if (req && !wb_we_i)
        begin
            case (wb_adr_i)
                csg_pkg::AMP_CONFIG_ADDR:
                begin
                    rdat_next[csg_pkg::EN_LSB +: PHASES] = en_reg;
                    rdat_next[csg_pkg::OFS_LSB +: csg_pkg::OFS_W] = ofs_reg;
                    rdat_next[csg_pkg::GAIN_LSB +: csg_pkg::GAIN_W] = gain_reg;
                    rdat_next[csg_pkg::TRUNC_BIT] = trunc_reg;
                end
                csg_pkg::SENSOR_CONFIG_ADDR:
                begin
                    rdat_next[csg_pkg::MODE_LSB +: csg_pkg::MODE_W] = mode_reg;
                    rdat_next[csg_pkg::RDSON_BIT] = rdson_reg;
                    rdat_next[csg_pkg::SINGLE_BIT] = single_reg;
                    rdat_next[csg_pkg::CALIB_BIT] = calib_reg;
                end
                csg_pkg::OCP_LEVEL_ADDR:
                begin
                    rdat_next[csg_pkg::PTHR_LSB +: csg_pkg::THR_W] = pthr_reg;
                    rdat_next[csg_pkg::NTHR_LSB +: csg_pkg::THR_W] = nthr_reg;
                end
                csg_pkg::BLANK_TIME_ADDR:
                begin
                    rdat_next[BLANK_W-1:0] = blank_reg;
                end
                csg_pkg::STATUS_ADDR:
                begin
                    rdat_next[csg_pkg::ST_CONN_LSB +: PHASES] = conn;
                    rdat_next[csg_pkg::ST_BLANK_LSB +: PHASES] = blnk;
                    rdat_next[csg_pkg::ST_POS_LSB +: PHASES] = pos_s;
                    rdat_next[csg_pkg::ST_NEG_LSB +: PHASES] = neg_s;
                    rdat_next[csg_pkg::ST_DRV_BIT] = drv_s;
                end
                default:
                begin
                    rdat_next = '0;
                end
            endcase
        end
        trn_next = trunc_reg ? pos_s : '0;
        // two or more enabled amplifiers always use their own phase
        shared_gate = single_reg && ($countones(en_reg) < MULTI_AMPS);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            en_reg <= csg_pkg::EN_RST;
            ofs_reg <= csg_pkg::OFS_RST;
            gain_reg <= csg_pkg::GAIN_RST;
            trunc_reg <= 1'b0;
            mode_reg <= csg_pkg::CSG_LOW_GATE_ON;
            rdson_reg <= 1'b0;
            single_reg <= 1'b0;
            calib_reg <= 1'b0;
            pthr_reg <= csg_pkg::THR_RST;
            nthr_reg <= csg_pkg::THR_RST;
            blank_reg <= csg_pkg::BLANK_RST;
            ack_reg <= 1'b0;
            rdat_reg <= '0;
            trn_reg <= '0;
        end
        else
        begin
            en_reg <= en_next;
            ofs_reg <= ofs_next;
            gain_reg <= gain_next;
            trunc_reg <= trunc_next;
            mode_reg <= mode_next;
            rdson_reg <= rdson_next;
            single_reg <= single_next;
            calib_reg <= calib_next;
            pthr_reg <= pthr_next;
            nthr_reg <= nthr_next;
            blank_reg <= blank_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            trn_reg <= trn_next;
        end
    end

    // ----------------------------------------
    // per phase gating
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < PHASES; g++)
        begin : ph
            csg_phase #(
                .BLANK_W(BLANK_W)
            ) u_phase (
                .sys_clk(sys_clk),
                .reset(reset),
                .enable(en_reg[g]),
                .mode(mode_reg),
                .single_shunt(shared_gate),
                .blank_len(blank_reg),
                .gl_own(gl_s[g]),
                .gl_any(|gl_s),
                .gh_own(gh_s[g]),
                .gh_all(&gh_s),
                .connect(conn[g]),
                .blanking(blnk[g]),
                .autozero(az[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign sense_output_n = conn;
    assign input_blank = blnk;
    assign autozero_pulse = az;
    assign amp_enable = en_reg;
    assign drain_to_positive = rdson_reg;
    assign offset_select = ofs_reg;
    assign gain_select = gain_reg;
    assign pos_threshold = pthr_reg;
    assign neg_threshold = nthr_reg;
    assign calibration_mode = calib_reg;
    assign pwm_truncate = trn_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    rdson_forces_mode_a: assert property (@(posedge sys_clk) disable iff (reset)
        rdson_reg |-> mode_reg == csg_pkg::CSG_LOW_GATE_ON)
        else $error("mode not forced in on-resistance sensing");
    ack_single_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
        (wb_cyc_i && wb_stb_i && !ack_reg) |=> ack_reg ##1 !ack_reg)
        else $error("bus ack not a single pulse");
    truncate_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
        !trunc_reg |=> pwm_truncate == '0) else $error("truncation while disabled");
    threshold_write_a: assert property (@(posedge sys_clk) disable iff (reset)
        (wr && wb_adr_i == csg_pkg::OCP_LEVEL_ADDR)
        |=> pos_threshold == $past(wb_dat_i[csg_pkg::PTHR_LSB +: csg_pkg::THR_W]))
        else $error("threshold not stored");
endmodule

// File: verification/csg_gate_model.sv
`timescale 1ns/1ps
module csg_gate_model #(
    parameter int DEAD = 12
) (
    // clock
    input wire logic sys_clk,
    // commands from the bench
    input wire logic [2:0] hs_cmd,
    input wire logic [2:0] ls_cmd,
    // gate pins
    output logic [2:0] high_side_gate_n,
    output logic [2:0] low_side_gate_n
);
    // ------------------------------------------------------------
    // dead time keeper
    // ------------------------------------------------------------
    int hs_off [3];
    int ls_off [3];
    initial
    begin
        high_side_gate_n = 3'h0;
        low_side_gate_n = 3'h0;
        for (int p = 0; p < 3; p++)
        begin
            hs_off[p] = DEAD;
            ls_off[p] = DEAD;
        end
    end
    always @(posedge sys_clk)
    begin
        for (int p = 0; p < 3; p++)
        begin
            // one side turns on only after the other has been off a full dead time
            high_side_gate_n[p] <= hs_cmd[p] && !ls_cmd[p] && ls_off[p] >= DEAD;
            low_side_gate_n[p] <= ls_cmd[p] && !hs_cmd[p] && hs_off[p] >= DEAD;
            hs_off[p] <= high_side_gate_n[p] ? 0 : (hs_off[p] < DEAD ? hs_off[p] + 1 : DEAD);
            ls_off[p] <= low_side_gate_n[p] ? 0 : (ls_off[p] < DEAD ? ls_off[p] + 1 : DEAD);
        end
    end
endmodule

// File: verification/csg_top_test.sv
`timescale 1ns/1ps
module csg_top_test;
    localparam int DEAD = 12;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [2:0] hs_cmd = 3'h0;
    logic [2:0] ls_cmd = 3'h0;
    logic [2:0] pos_comp_in = 3'h0;
    logic [2:0] neg_comp_in = 3'h0;
    logic driver_enable_pin = 1'b0;
    logic [2:0] low_side_gate_n, high_side_gate_n, sense_output_n, input_blank;
    logic [2:0] autozero_pulse, amp_enable, gain_select, pwm_truncate;
    logic [3:0] pos_threshold, neg_threshold;
    logic [1:0] offset_select;
    logic drain_to_positive, calibration_mode;
    logic [31:0] rd;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    csg_top dut_u (
        .sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .low_side_gate_n, .high_side_gate_n, .pos_comp_in,
        .neg_comp_in, .driver_enable_pin, .sense_output_n, .input_blank, .autozero_pulse,
        .amp_enable, .drain_to_positive, .offset_select, .gain_select, .pos_threshold,
        .neg_threshold, .calibration_mode, .pwm_truncate
    );
    csg_gate_model #(.DEAD(DEAD)) gm_u (
        .sys_clk, .hs_cmd, .ls_cmd, .high_side_gate_n, .low_side_gate_n
    );

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        chk("bus ack", 32'h1, {31'h0, wb_ack_o});
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        wb(1'b1, adr, 4'hF, wd);
    endtask
    task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 4'hF, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic gates(input logic [2:0] ls, input logic [2:0] hs);
        @(posedge sys_clk);
        ls_cmd <= ls;
        hs_cmd <= hs;
        repeat (2 * DEAD + 6) @(posedge sys_clk);
    endtask
    function automatic logic [2:0] exp_conn(input logic [1:0] m, input logic [2:0] en,
        input logic single, input logic [2:0] gl, input logic [2:0] gh);
        logic [2:0] r;
        logic shared;
        shared = single && ($countones(en) < 2);
        for (int p = 0; p < 3; p++)
        begin
            case (m)
                2'h0: r[p] = shared ? |gl : gl[p];
                2'h1: r[p] = shared ? ~&gh : ~gh[p];
                2'h2: r[p] = 1'b1;
                default: r[p] = 1'b0;
            endcase
        end
        return r & en;
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int a = 0; a <= 20; a += 4)
            rdchk("reset value", 8'(a), 32'h0);
        chk("offset", 32'h0, {30'h0, offset_select});
        $display("test reset done");
    endtask
    task automatic t_modes();
        logic [2:0] en;
        gates(3'h3, 3'h4);
        // pass 0 three shunt, pass 1 one amplifier single shunt, pass 2 two amplifiers
        for (int s = 0; s < 3; s++)
        begin
            en = (s == 1) ? 3'h4 : 3'h5;
            wr(csg_pkg::AMP_CONFIG_ADDR, 32'(en));
            for (int m = 0; m < 4; m++)
            begin
                wr(csg_pkg::SENSOR_CONFIG_ADDR, 32'((s != 0) * 8 + m));
                repeat (4) @(posedge sys_clk);
                chk("connect", exp_conn(2'(m), en, s != 0, low_side_gate_n,
                    high_side_gate_n), sense_output_n);
            end
        end
        $display("test modes done");
    endtask
    task automatic t_dead();
        for (int m = 0; m < 2; m++)
        begin
            wr(csg_pkg::SENSOR_CONFIG_ADDR, 32'(m));
            gates(3'h1, 3'h0);
            @(posedge sys_clk);
            ls_cmd <= 3'h0;
            hs_cmd <= 3'h1;
            repeat (8) @(posedge sys_clk);
            chk("dead time connect", 32'(m), {31'h0, sense_output_n[0]});
        end
        $display("test dead done");
    endtask
    task automatic t_blank();
        int nb;
        int nz;
        nb = 0;
        nz = 0;
        wr(csg_pkg::BLANK_TIME_ADDR, 32'h4);
        wr(csg_pkg::SENSOR_CONFIG_ADDR, 32'h0);
        gates(3'h1, 3'h0);
        @(posedge sys_clk);
        ls_cmd <= 3'h0;
        hs_cmd <= 3'h1;
        repeat (2 * DEAD + 10)
        begin
            @(posedge sys_clk);
            nb += int'(input_blank[0] === 1'b1);
            nz += int'(autozero_pulse[0] === 1'b1);
        end
        chk("blank cycles", 32'h4, 32'(nb));
        chk("autozero pulses", 32'h1, 32'(nz));
        $display("test blank done");
    endtask
    task automatic t_rdson();
        wr(csg_pkg::SENSOR_CONFIG_ADDR, 32'h6);
        rdchk("mode forced", csg_pkg::SENSOR_CONFIG_ADDR, 32'h4);
        chk("drain routing", 32'h1, {31'h0, drain_to_positive});
        wr(csg_pkg::SENSOR_CONFIG_ADDR, 32'h5);
        rdchk("mode kept", csg_pkg::SENSOR_CONFIG_ADDR, 32'h4);
        wr(csg_pkg::SENSOR_CONFIG_ADDR, 32'h2);
        rdchk("mode free", csg_pkg::SENSOR_CONFIG_ADDR, 32'h2);
        chk("source routing", 32'h0, {31'h0, drain_to_positive});
        $display("test rdson done");
    endtask
    task automatic t_cfg();
        for (int k = 0; k < 4; k++)
        begin
            wr(csg_pkg::AMP_CONFIG_ADDR, 32'((k + 3) * 32 + k * 8 + 7));
            chk("offset", 32'(k), {30'h0, offset_select});
            chk("gain", 32'(k + 3), {29'h0, gain_select});
            chk("enables", 32'h7, {29'h0, amp_enable});
        end
        wr(csg_pkg::OCP_LEVEL_ADDR, 32'hA5);
        chk("thresholds", 32'hA5, {24'h0, neg_threshold, pos_threshold});
        pos_comp_in <= 3'h2;
        neg_comp_in <= 3'h4;
        wb(1'b1, csg_pkg::AMP_CONFIG_ADDR, 4'h1, 32'h100);
        chk("truncate masked", 32'h0, {29'h0, pwm_truncate});
        wr(csg_pkg::AMP_CONFIG_ADDR, 32'h100);
        repeat (4) @(posedge sys_clk);
        chk("truncate", 32'h2, {29'h0, pwm_truncate});
        rdchk("status comps", csg_pkg::STATUS_ADDR, 32'h880);
        wr(8'h14, 32'hFF);
        rdchk("unmapped", 8'h14, 32'h0);
        rdchk("amp kept", csg_pkg::AMP_CONFIG_ADDR, 32'h100);
        $display("test cfg done");
    endtask
    task automatic t_cal();
        wr(csg_pkg::SENSOR_CONFIG_ADDR, 32'h10);
        chk("calibration", 32'h1, {31'h0, calibration_mode});
        wr(csg_pkg::SENSOR_CONFIG_ADDR, 32'h0);
        driver_enable_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wb(1'b0, csg_pkg::STATUS_ADDR, 4'hF, 32'h0);
        chk("driver status", 32'h1000, rd & 32'h1000);
        $display("test cal done");
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_modes();
        t_dead();
        t_blank();
        t_rdson();
        t_cfg();
        t_cal();
        print_verdict();
    end
endmodule
